// >>> design/mpc_pkg.sv
/*
 Constants for the motor protection controller: register byte offsets,
 field positions, reset values and gate patterns.
 Assumes a 32-bit APB with 12-bit byte addresses.
*/
package mpc_pkg;
  // Register byte offsets
  localparam logic [11:0] ADDR_ENABLE = 12'h000;
  localparam logic [11:0] ADDR_POLICY = 12'h004;
  localparam logic [11:0] ADDR_FLAGS = 12'h008;
  localparam logic [11:0] ADDR_END = 12'h00C;
  localparam logic [11:0] ADDR_STATUS = 12'h010;
  // protection_enable_ctrl fields
  localparam int EN_LIMIT_BIT = 2;
  localparam int EN_OVER_BIT = 3;
  localparam int EN_CMP_BIT = 4;
  localparam int EN_OVF_BIT = 5;
  localparam int EN_SWEN_BIT = 6;
  localparam int EN_SWVAL_BIT = 7;
  localparam logic [7:0] ENABLE_MASK = 8'hFC;
  localparam logic [7:0] ENABLE_RST = 8'h00;
  // protection_policy_select fields
  localparam int POL_OVF_BIT = 0;
  localparam int POL_CMP_BIT = 1;
  localparam int POL_OVER_BIT = 2;
  localparam int POL_LIMIT_BIT = 3;
  localparam int POL_SW_BIT = 4;
  localparam logic [7:0] POLICY_MASK = 8'h1F;
  localparam logic [7:0] POLICY_RST = 8'h13;
  // motor_control_flags_reg fields
  localparam int FLAGS_FREE_RUN_BIT = 0;
  localparam logic [7:0] FLAGS_MASK = 8'h01;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  // Trigger channel indices
  localparam int CH_LIMIT = 0;
  localparam int CH_OVER = 1;
  localparam int CH_CMP = 2;
  localparam int CH_OVF = 3;
  localparam int CH_SW = 4;
  localparam int NUM_CH = 5;
  localparam int STAT_HOLD_BIT = 5;
  localparam int STAT_ANY_BIT = 6;
  // Gate order {upper A, lower A, upper B, lower B, upper C, lower C}
  localparam logic [5:0] GATE_BRAKE = 6'h15;
  localparam logic [5:0] GATE_FREE = 6'h00;
endpackage : mpc_pkg

// >>> design/mpc_sync.sv
/*
 Two-flop synchroniser for a vector of independent level inputs.
 Assumes each bit is a slow level from outside the pclk domain.
*/
`timescale 1ns/10ps
`default_nettype none
module mpc_sync #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Data
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_reg;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_reg[i] <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          meta_reg[i] <= async_in[i];
          sync_out[i] <= meta_reg[i];
        end
      end
    end
  endgenerate
endmodule : mpc_sync
`default_nettype wire

// >>> design/mpc_channel.sv
/*
 One protection trigger channel with fault or pause restart policy.
 Assumes trigger is already synchronised to pclk and end_pulse is one cycle.
*/
`timescale 1ns/10ps
`default_nettype none
module mpc_channel (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic enable,
  input wire logic pause_mode,
  input wire logic end_pulse,
  // Trigger and result
  input wire logic trigger,
  output logic active
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active <= 1'b0;
    end else if (!enable) begin
      active <= 1'b0;
    end else if (pause_mode) begin
      // Trigger wins over a software end in the same cycle
      active <= trigger | (active & ~end_pulse); // [R3]
    end else begin
      active <= trigger; // [R2]
    end
  end

  property p_fault_follow;
    @(posedge pclk) disable iff (!presetn)
    (enable && !pause_mode) |=> (active == $past(trigger));
  endproperty
  a_fault_follow: assert property (p_fault_follow) // [R2]
    else $error("fault policy does not follow trigger");

  property p_pause_hold;
    @(posedge pclk) disable iff (!presetn)
    (enable && pause_mode && active && !end_pulse) |=> active;
  endproperty
  a_pause_hold: assert property (p_pause_hold) // [R3]
    else $error("pause protection released without software end");

  property p_disabled;
    @(posedge pclk) disable iff (!presetn)
    (!enable) [*2] |-> !active;
  endproperty
  a_disabled: assert property (p_disabled) // [R4]
    else $error("disabled channel is active");
endmodule : mpc_channel
`default_nettype wire

// >>> design/mpc_top.sv
/*
 Motor protection controller: gates six PWM gate-drive signals to brake
 or free-run while any enabled trigger holds protection.
 Assumes an APB master on pclk, PWM gate inputs and the period-start
 pulse from logic on pclk, and trigger levels from outside this domain.
*/
// Decided for this implementation: the APB slave port and the register addresses.
// Summary of operation
// R1 - Protection drives brake or free-run pattern
// R2 - Fault policy follows the trigger level
// R3 - Pause policy holds until software ends
// R4 - Current-limit path acts only when enabled
// R5 - Limit restart immediate or at period start
// R6 - Software routes converter to amplifier output
// R7 - Over-current path acts only when enabled
// R8 - Over-current shuts outputs without software
// R9 - Software restarts PWM after over-current
// R10 - Software uses fault policy for current
// R11 - Compare stall path acts only when enabled
// R12 - Overflow stall path acts only when enabled
// R13 - Capture timer raises compare or overflow event
// R14 - Soft value bit7, enable bit6, reset zero
// R15 - Soft policy bit4, resets to pause
// R16 - Compare policy bit1, resets to pause
// R17 - Software keeps over-current policy at pause
// R18 - Software keeps overflow policy at pause
// R19 - Unimplemented register bits read as zero
// R20 - Active protection overrides PWM gate outputs
`timescale 1ns/10ps
`default_nettype none
module mpc_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Trigger inputs
  input wire logic current_limit_irq,
  input wire logic overcurrent_irq,
  input wire logic stall_compare_irq,
  input wire logic stall_overflow_irq,
  // PWM side
  input wire logic [5:0] pwm_gate_in,
  input wire logic pwm_period_start,
  // Gate drive
  output logic [5:0] gate_out,
  output logic protect_active
);
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a[11:2] == off[11:2]);
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    mapped = hit(a, mpc_pkg::ADDR_ENABLE) | hit(a, mpc_pkg::ADDR_POLICY) |
             hit(a, mpc_pkg::ADDR_FLAGS) | hit(a, mpc_pkg::ADDR_END) |
             hit(a, mpc_pkg::ADDR_STATUS);
  endfunction

  logic [7:0] enable_reg;
  logic [7:0] policy_reg;
  logic [7:0] flags_reg;
  logic limit_hold_reg;
  logic [3:0] trig_sync;
  logic [mpc_pkg::NUM_CH-1:0] ch_trig;
  logic [mpc_pkg::NUM_CH-1:0] ch_en;
  logic [mpc_pkg::NUM_CH-1:0] ch_pause;
  logic [mpc_pkg::NUM_CH-1:0] ch_end;
  logic [mpc_pkg::NUM_CH-1:0] ch_active;
  logic setup;
  logic wr_en;
  logic limit_eff;
  logic protect_any;
  logic [5:0] gate_next;
  logic [31:0] rdata_next;

  // APB phases; one wait-free access after each setup
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready & pwrite;

  // Trigger inputs from comparator and capture timer
  mpc_sync #(
    .W(4)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({stall_overflow_irq, stall_compare_irq,
               overcurrent_irq, current_limit_irq}), // [R13]
    .sync_out(trig_sync)
  );

  // Channel wiring: trigger, enable and policy per source
  assign ch_trig = {enable_reg[mpc_pkg::EN_SWVAL_BIT], trig_sync}; // [R14]
  assign ch_en[mpc_pkg::CH_LIMIT] = enable_reg[mpc_pkg::EN_LIMIT_BIT]; // [R4]
  assign ch_en[mpc_pkg::CH_OVER] = enable_reg[mpc_pkg::EN_OVER_BIT]; // [R7]
  assign ch_en[mpc_pkg::CH_CMP] = enable_reg[mpc_pkg::EN_CMP_BIT]; // [R11]
  assign ch_en[mpc_pkg::CH_OVF] = enable_reg[mpc_pkg::EN_OVF_BIT]; // [R12]
  assign ch_en[mpc_pkg::CH_SW] = enable_reg[mpc_pkg::EN_SWEN_BIT]; // [R14]
  // Current limit always follows its source; its policy bit picks restart
  assign ch_pause[mpc_pkg::CH_LIMIT] = 1'b0;
  // Over-current latches until software restarts PWM only in pause policy; reset selects fault
  assign ch_pause[mpc_pkg::CH_OVER] = policy_reg[mpc_pkg::POL_OVER_BIT];
  assign ch_pause[mpc_pkg::CH_CMP] = policy_reg[mpc_pkg::POL_CMP_BIT]; // [R16]
  assign ch_pause[mpc_pkg::CH_OVF] = policy_reg[mpc_pkg::POL_OVF_BIT];
  assign ch_pause[mpc_pkg::CH_SW] = policy_reg[mpc_pkg::POL_SW_BIT]; // [R15]
  assign ch_end = (wr_en && hit(paddr, mpc_pkg::ADDR_END)) ?
                  pwdata[mpc_pkg::NUM_CH-1:0] : '0;

  genvar c;
  generate
    for (c = 0; c < mpc_pkg::NUM_CH; c++) begin : g_ch
      mpc_channel u_ch (
        .pclk(pclk),
        .presetn(presetn),
        .enable(ch_en[c]),
        .pause_mode(ch_pause[c]),
        .end_pulse(ch_end[c]),
        .trigger(ch_trig[c]),
        .active(ch_active[c])
      );
    end
  endgenerate

  // Delayed restart after the limit source clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      limit_hold_reg <= 1'b0;
    end else if (!ch_en[mpc_pkg::CH_LIMIT]) begin
      limit_hold_reg <= 1'b0;
    end else if (ch_active[mpc_pkg::CH_LIMIT] &&
                 policy_reg[mpc_pkg::POL_LIMIT_BIT]) begin
      limit_hold_reg <= 1'b1; // [R5]
    end else if (pwm_period_start) begin
      limit_hold_reg <= 1'b0; // [R5]
    end
  end

  assign limit_eff = ch_active[mpc_pkg::CH_LIMIT] | limit_hold_reg;
  assign protect_any = limit_eff |
                       (|ch_active[mpc_pkg::NUM_CH-1:mpc_pkg::CH_OVER]);

  // Gate override
  always_comb begin
    if (protect_any) begin
      gate_next = flags_reg[mpc_pkg::FLAGS_FREE_RUN_BIT] ?
                  mpc_pkg::GATE_FREE : mpc_pkg::GATE_BRAKE; // [R1]
    end else begin
      gate_next = pwm_gate_in;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_out <= mpc_pkg::GATE_FREE;
      protect_active <= 1'b0;
    end else begin
      gate_out <= gate_next; // [R20] [R8]
      protect_active <= protect_any;
    end
  end

  // Control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_reg <= mpc_pkg::ENABLE_RST; // [R14]
      policy_reg <= mpc_pkg::POLICY_RST; // [R15] [R16]
      flags_reg <= mpc_pkg::FLAGS_RST;
    end else if (wr_en) begin
      if (hit(paddr, mpc_pkg::ADDR_ENABLE)) begin
        enable_reg <= pwdata[7:0] & mpc_pkg::ENABLE_MASK; // [R19]
      end
      if (hit(paddr, mpc_pkg::ADDR_POLICY)) begin
        policy_reg <= pwdata[7:0] & mpc_pkg::POLICY_MASK; // [R19]
      end
      if (hit(paddr, mpc_pkg::ADDR_FLAGS)) begin
        flags_reg <= pwdata[7:0] & mpc_pkg::FLAGS_MASK;
      end
    end
  end

  // Read data mux
  always_comb begin
    rdata_next = '0;
    if (hit(paddr, mpc_pkg::ADDR_ENABLE)) begin
      rdata_next[7:0] = enable_reg;
    end else if (hit(paddr, mpc_pkg::ADDR_POLICY)) begin
      rdata_next[7:0] = policy_reg;
    end else if (hit(paddr, mpc_pkg::ADDR_FLAGS)) begin
      rdata_next[7:0] = flags_reg;
    end else if (hit(paddr, mpc_pkg::ADDR_STATUS)) begin
      rdata_next[mpc_pkg::NUM_CH-1:0] = ch_active;
      rdata_next[mpc_pkg::STAT_HOLD_BIT] = limit_hold_reg;
      rdata_next[mpc_pkg::STAT_ANY_BIT] = protect_any;
    end
  end

  // APB answer: ready and data registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else if (setup) begin
      pready <= 1'b1;
      pslverr <= ~mapped(paddr);
      prdata <= pwrite ? '0 : rdata_next;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end
  end

  sequence s_protect;
    protect_any;
  endsequence

  property p_gate_pattern;
    @(posedge pclk) disable iff (!presetn)
    s_protect |=> (gate_out == ($past(flags_reg[mpc_pkg::FLAGS_FREE_RUN_BIT]) ?
                   mpc_pkg::GATE_FREE : mpc_pkg::GATE_BRAKE));
  endproperty
  a_gate_pattern: assert property (p_gate_pattern) // [R1]
    else $error("gate pattern wrong while protecting");

  property p_gate_pass;
    @(posedge pclk) disable iff (!presetn)
    !protect_any |=> (gate_out == $past(pwm_gate_in)) && !protect_active;
  endproperty
  a_gate_pass: assert property (p_gate_pass) // [R20]
    else $error("gate output not following PWM");

  sequence s_over_seen;
    ch_en[mpc_pkg::CH_OVER] && trig_sync[mpc_pkg::CH_OVER];
  endsequence

  property p_over_shut;
    @(posedge pclk) disable iff (!presetn)
    s_over_seen ##1 ch_en[mpc_pkg::CH_OVER] |=> protect_active;
  endproperty
  a_over_shut: assert property (p_over_shut) // [R8]
    else $error("over-current did not shut outputs in two cycles");

  property p_limit_wait;
    @(posedge pclk) disable iff (!presetn)
    (limit_hold_reg && !ch_active[mpc_pkg::CH_LIMIT] && !pwm_period_start &&
     ch_en[mpc_pkg::CH_LIMIT]) |=> limit_hold_reg;
  endproperty
  a_limit_wait: assert property (p_limit_wait) // [R5]
    else $error("limit restart before next period");

  property p_limit_now;
    @(posedge pclk) disable iff (!presetn)
    (!policy_reg[mpc_pkg::POL_LIMIT_BIT] && !limit_hold_reg) |=> !limit_hold_reg;
  endproperty
  a_limit_now: assert property (p_limit_now) // [R5]
    else $error("limit hold with immediate restart");

  property p_reserved;
    @(posedge pclk) disable iff (!presetn)
    (enable_reg[1:0] == 2'b00) && (policy_reg[7:5] == 3'b000);
  endproperty
  a_reserved: assert property (p_reserved) // [R19]
    else $error("unimplemented bits not zero");

  property p_apb_answer;
    @(posedge pclk) disable iff (!presetn)
    setup |=> pready ##1 !pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer)
    else $error("APB ready not one cycle after setup");

  property p_enable_write;
    @(posedge pclk) disable iff (!presetn)
    (wr_en && hit(paddr, mpc_pkg::ADDR_ENABLE)) |=>
    (enable_reg[7:2] == $past(pwdata[7:2]));
  endproperty
  a_enable_write: assert property (p_enable_write) // [R4] [R14]
    else $error("enable register write lost");

  property p_limit_set;
    @(posedge pclk) disable iff (!presetn)
    (ch_en[mpc_pkg::CH_LIMIT] && ch_active[mpc_pkg::CH_LIMIT] &&
     policy_reg[mpc_pkg::POL_LIMIT_BIT]) |=> limit_hold_reg;
  endproperty
  a_limit_set: assert property (p_limit_set) // [R5]
    else $error("limit hold not set while limiting");

  property p_limit_clear;
    @(posedge pclk) disable iff (!presetn)
    (ch_en[mpc_pkg::CH_LIMIT] && !ch_active[mpc_pkg::CH_LIMIT] && pwm_period_start) |=>
    !limit_hold_reg;
  endproperty
  a_limit_clear: assert property (p_limit_clear) // [R5]
    else $error("limit hold kept past period start");

  sequence s_over_ended;
    wr_en && hit(paddr, mpc_pkg::ADDR_END) && pwdata[mpc_pkg::CH_OVER] &&
    !trig_sync[mpc_pkg::CH_OVER];
  endsequence

  property p_over_end;
    @(posedge pclk) disable iff (!presetn)
    s_over_ended |=> !ch_active[mpc_pkg::CH_OVER];
  endproperty
  a_over_end: assert property (p_over_end) // [R3]
    else $error("over-current protection not ended by software");
endmodule : mpc_top
`default_nettype wire

// >>> sim/mpc_gate_model.sv
/*
 Behavioural model of the three external gate-drive transistor pairs.
 Assumes gate order {upper A, lower A, upper B, lower B, upper C, lower C}.
*/
`timescale 1ns/10ps
`default_nettype none
module mpc_gate_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Gate drive
  input wire logic [5:0] gate,
  // Observation
  output logic shoot_seen
);
  // A pair with both arms on shorts the supply; the flag stays set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shoot_seen <= 1'b0;
    end else if ((gate[5] & gate[4]) | (gate[3] & gate[2]) | (gate[1] & gate[0])) begin
      shoot_seen <= 1'b1;
    end
  end
endmodule : mpc_gate_model
`default_nettype wire

// >>> sim/test_mpc_top.sv
/*
 Self-checking bench for the motor protection controller.
 Assumes the design's APB answers in the access cycle.
*/
`timescale 1ns/10ps
`default_nettype none
module test_mpc_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] trg = 4'h0;
  logic [5:0] pwm = 6'h2A;
  logic pstart = 1'b0;
  logic [5:0] gate_out;
  logic protect_active;
  logic shoot_seen;
  logic [31:0] r;
  logic e;
  int err_count = 0;
  int checked = 0;
  mpc_top dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .current_limit_irq(trg[0]),
    .overcurrent_irq(trg[1]), .stall_compare_irq(trg[2]),
    .stall_overflow_irq(trg[3]), .pwm_gate_in(pwm), .pwm_period_start(pstart),
    .gate_out(gate_out), .protect_active(protect_active)
  );
  mpc_gate_model gm (.pclk(pclk), .presetn(presetn), .gate(gate_out), .shoot_seen(shoot_seen));
  initial begin
    forever #5 pclk = ~pclk;
  end
  task end_sim();
    $display("checked %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim
  task chk(input logic [31:0] g, input logic [31:0] x, input string m);
    checked++;
    if (g !== x) begin
      err_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, x);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      chk(32'h0000_0000, 32'h0000_0001, "pready timeout");
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rd(input logic [11:0] a, input logic [7:0] x, input logic xe);
    apb(1'b0, a, 8'h00);
    chk(r, {24'h00_0000, x}, "read data");
    chk({31'h0000_0000, e}, {31'h0000_0000, xe}, "slave error");
  endtask : rd
  task cyc(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : cyc
  task gates(input logic [5:0] x, input logic pa);
    chk({26'h000_0000, gate_out}, {26'h000_0000, x}, "gate pattern");
    chk({31'h0000_0000, protect_active}, {31'h0000_0000, pa}, "protect flag");
  endtask : gates
  initial begin
    #100000;
    err_count++;
    end_sim();
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(mpc_pkg::ADDR_ENABLE, 8'h00, 1'b0);
    rd(mpc_pkg::ADDR_POLICY, 8'h13, 1'b0);
    apb(1'b1, mpc_pkg::ADDR_ENABLE, 8'h03);
    rd(mpc_pkg::ADDR_ENABLE, 8'h00, 1'b0);
    apb(1'b1, mpc_pkg::ADDR_POLICY, 8'hF5);
    rd(mpc_pkg::ADDR_POLICY, 8'h15, 1'b0);
    rd(12'h020, 8'h00, 1'b1);
    cyc(2);
    gates(6'h2A, 1'b0);
    // Each hardware path: ignored while disabled, then brakes
    for (int i = 0; i < 4; i++) begin
      @(posedge pclk);
      trg[i] <= 1'b1;
      cyc(8);
      gates(6'h2A, 1'b0);
      apb(1'b1, mpc_pkg::ADDR_ENABLE, 8'h04 << i);
      cyc(8);
      gates(mpc_pkg::GATE_BRAKE, 1'b1);
      rd(mpc_pkg::ADDR_STATUS, 8'h40 | (8'h01 << i), 1'b0);
      @(posedge pclk);
      trg[i] <= 1'b0;
      cyc(8);
      if (i == 0 || i == 2) begin
        gates(6'h2A, 1'b0);
      end else begin
        gates(mpc_pkg::GATE_BRAKE, 1'b1);
        apb(1'b1, mpc_pkg::ADDR_END, 8'h01 << i);
        cyc(4);
        gates(6'h2A, 1'b0);
      end
      apb(1'b1, mpc_pkg::ADDR_ENABLE, 8'h00);
    end
    // Software trigger in fault policy, free-running pattern
    apb(1'b1, mpc_pkg::ADDR_FLAGS, 8'h01);
    apb(1'b1, mpc_pkg::ADDR_POLICY, 8'h05);
    apb(1'b1, mpc_pkg::ADDR_ENABLE, 8'hC0);
    cyc(8);
    gates(mpc_pkg::GATE_FREE, 1'b1);
    apb(1'b1, mpc_pkg::ADDR_ENABLE, 8'h40);
    cyc(8);
    gates(6'h2A, 1'b0);
    // Limit path waits for the next period start
    apb(1'b1, mpc_pkg::ADDR_FLAGS, 8'h00);
    apb(1'b1, mpc_pkg::ADDR_POLICY, 8'h1D);
    apb(1'b1, mpc_pkg::ADDR_ENABLE, 8'h04);
    trg[0] <= 1'b1;
    cyc(8);
    gates(mpc_pkg::GATE_BRAKE, 1'b1);
    @(posedge pclk);
    trg[0] <= 1'b0;
    cyc(12);
    gates(mpc_pkg::GATE_BRAKE, 1'b1);
    rd(mpc_pkg::ADDR_STATUS, 8'h60, 1'b0);
    @(posedge pclk);
    pstart <= 1'b1;
    @(posedge pclk);
    pstart <= 1'b0;
    cyc(3);
    gates(6'h2A, 1'b0);
    chk({31'h0000_0000, shoot_seen}, 32'h0000_0000, "shoot through");
    end_sim();
  end
endmodule : test_mpc_top
`default_nettype wire
